// *** hw/sync_slave_serial.sv ***
// Operation
// [R1] Port runs during sleep only as synchronous slave; else shifters stop.
// [R2] Master and asynchronous modes make no shift activity while asleep.
// [R3] Slave shift registers clock only from the external clock pin.
// [R4] Software empties received data before sleep, clearing the flag.
// [R5] Software sets receive, peripheral and global enables for wake; receive wake here needs only the receive enable.
// [R6] Asleep in slave receive, data and clocks are accepted from master.
// [R7] A complete received word sets the receive flag and wakes.
// [R8] Wake resumes next instruction; global enable calls fixed vector.
// [R9] Software fills transmit shift and buffer before sleep.
// [R10] Software sets transmit and peripheral enables for transmit wake.
// [R11] Asleep in slave transmit, clocks accepted and data driven.
// [R12] After word out, buffered byte moves in; transmit flag set, wakes.
// [R13] Writing transmit data after wake clears transmit-empty flag.
// [R14] Unimplemented register bits read as zero.
// [R15] Clock and data pins relocate under alternate pin register.
// [R16] Slave selected by sync set, clock source clear, enable set.
// [R17] Slave receive uses continuous enable; single enable ignored.
// [R18] Overrun cleared by clearing continuous enable or port enable.
// [R19] Eight data bits plus optional ninth bit in control register.
// [R20] LSB first, one bit per edge, edges chosen by polarity.
`timescale 1ns/10ps
module sync_slave_serial (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [5:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic             waitrequest_out,
  output logic [31:0]      readdata_out,
  input  wire logic        sleep_in,
  input  wire logic [1:0]  clock_pin_in,
  input  wire logic [1:0]  data_pin_in,
  output logic [1:0]       data_pin_out,
  output logic [1:0]       data_pin_oe_out,
  output logic             wake_out,
  output logic             irq_out,
  output logic [11:0]      irq_vector_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  apf;
    logic [7:0]  baud;
    logic [7:0]  intc;
    logic [7:0]  pie;
    logic [7:0]  pir;
    logic [7:0]  receive_status_control;
    logic [7:0]  transmit_status_control;
    logic [7:0]  port_c_direction;
    logic [7:0]  receive_data;
    logic        rx_ninth_bit;
    logic        rx_complete_flag;
    logic        overrun_error;
    logic [8:0]  rx_shift_reg;
    logic [3:0]  rcnt;
    logic [8:0]  txbuf;
    logic        txbuf_full;
    logic [8:0]  tx_shift_reg;
    logic        tsr_full;
    logic [3:0]  tcnt;
    logic        tpend;
    logic        ck_prev;
    logic [1:0]  dout;
    logic [1:0]  doe;
    logic [31:0] rdata;
    logic        wake;
    logic        irq;
  } serial_st_t;

  serial_st_t                  st_r;
  serial_st_t                  st_nxt;
  sync_slave_pkg::bus_acc_t    acc;
  sync_slave_pkg::link_pins_t  pins;
  logic                        slave;
  logic                        rx_mode;
  logic                        tx_mode;
  logic                        ck;
  logic                        drive_edge;
  logic                        sample_edge;
  logic                        din;
  logic                        rx_done;
  logic                        tx_done;
  logic                        tx_empty_flag;
  logic [3:0]                  rx_last;
  logic [3:0]                  tx_last;
  logic [7:0]                  rd_byte;

  // ----------------------------------------------------------------
  // Bus slave and pin synchroniser
  // ----------------------------------------------------------------
  bus_front u_front (
    .clk_in          (clk_in),
    .rstn_in         (rstn_in),
    .address_in      (address_in),
    .read_in         (read_in),
    .write_in        (write_in),
    .writedata_in    (writedata_in),
    .byteenable_in   (byteenable_in),
    .waitrequest_out (waitrequest_out),
    .acc_out         (acc)
  );

  pin_sync #(.W(4)) u_sync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    ({data_pin_in, clock_pin_in}),
    .level_out (pins)
  );

  // ----------------------------------------------------------------
  // Mode decode and link edges
  // ----------------------------------------------------------------
  always_comb begin
    slave   = sync_slave_pkg::slave_mode(st_r.receive_status_control, st_r.transmit_status_control); // R16 R1 R2
    // Single enable ignored in slave receive
    rx_mode = slave &
      st_r.receive_status_control[sync_slave_pkg::CONTINUOUS_RX_ENABLE]; // R17
    tx_mode = slave &
      ~st_r.receive_status_control[sync_slave_pkg::CONTINUOUS_RX_ENABLE] &
      ~st_r.receive_status_control[sync_slave_pkg::SINGLE_RX_ENABLE] &
      st_r.transmit_status_control[sync_slave_pkg::TX_ENABLE];
    ck  = pins.clk_lvl[st_r.apf[sync_slave_pkg::CLOCK_PIN_ALT]] ^
          st_r.baud[sync_slave_pkg::CLOCK_POLARITY]; // R15 R20
    din = pins.data_lvl[st_r.apf[sync_slave_pkg::DATA_PIN_ALT]]; // R15
    // Only the external clock's edges move the shifters
    drive_edge  = ck & ~st_r.ck_prev; // R3
    sample_edge = ~ck & st_r.ck_prev; // R3
    rx_last = st_r.receive_status_control[sync_slave_pkg::RX_NINE_BIT_SELECT] ?
              sync_slave_pkg::LAST_BIT_9 : sync_slave_pkg::LAST_BIT_8;
    tx_last = st_r.transmit_status_control[sync_slave_pkg::TX_NINE_BIT_SELECT] ?
              sync_slave_pkg::LAST_BIT_9 : sync_slave_pkg::LAST_BIT_8;
    rx_done = rx_mode & ~st_r.overrun_error & sample_edge & (st_r.rcnt == rx_last);
    tx_done = tx_mode & st_r.tsr_full & sample_edge &
              (st_r.tcnt == tx_last);
    tx_empty_flag    = ~st_r.txbuf_full;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = sync_slave_pkg::RESET_ZERO;
    unique case (acc.addr)
      sync_slave_pkg::OFS_ALT_PIN:    rd_byte = st_r.apf;
      sync_slave_pkg::OFS_BAUD: begin
        rd_byte = st_r.baud & sync_slave_pkg::BAUD_WR_MASK; // R14
        // Slave receiver is never idle while receiving
        rd_byte[sync_slave_pkg::RX_IDLE] = ~rx_mode;
      end
      sync_slave_pkg::OFS_GLOBAL_IRQ: rd_byte = st_r.intc;
      sync_slave_pkg::OFS_PERIPH_IE:  rd_byte = st_r.pie;
      sync_slave_pkg::OFS_PERIPH_IF: begin
        rd_byte = st_r.pir & sync_slave_pkg::FLAG_WR_MASK;
        rd_byte[sync_slave_pkg::RX_IRQ_BIT] = st_r.rx_complete_flag;
        rd_byte[sync_slave_pkg::TX_IRQ_BIT] = tx_empty_flag;
      end
      sync_slave_pkg::OFS_RX_DATA:    rd_byte = st_r.receive_data;
      sync_slave_pkg::OFS_RX_STATUS: begin
        rd_byte = st_r.receive_status_control & sync_slave_pkg::RX_CTRL_MASK;
        rd_byte[sync_slave_pkg::FRAMING_ERROR] = 1'b0;
        rd_byte[sync_slave_pkg::OVERRUN_ERROR] = st_r.overrun_error;
        rd_byte[sync_slave_pkg::RX_NINTH_BIT]  = st_r.rx_ninth_bit; // R19
      end
      sync_slave_pkg::OFS_PORT_C_DIR: rd_byte = st_r.port_c_direction;
      sync_slave_pkg::OFS_TX_STATUS: begin
        rd_byte = st_r.transmit_status_control & sync_slave_pkg::TX_CTRL_MASK;
        rd_byte[sync_slave_pkg::TX_SHIFT_EMPTY] = ~st_r.tsr_full;
      end
      default: rd_byte = sync_slave_pkg::RESET_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.ck_prev = ck;
    if (acc.rd_prep) begin
      st_nxt.rdata = {24'h00_0000, rd_byte};
    end
    // Reading data empties the holding register
    if (acc.rd_go && acc.addr == sync_slave_pkg::OFS_RX_DATA) begin
      st_nxt.rx_complete_flag = 1'b0; // R4
    end
    if (acc.wr_go && acc.lane0) begin
      unique case (acc.addr)
        sync_slave_pkg::OFS_ALT_PIN:    st_nxt.apf = acc.wdata;
        sync_slave_pkg::OFS_BAUD:
          st_nxt.baud = acc.wdata & sync_slave_pkg::BAUD_WR_MASK;
        sync_slave_pkg::OFS_GLOBAL_IRQ: st_nxt.intc = acc.wdata;
        sync_slave_pkg::OFS_PERIPH_IE:  st_nxt.pie = acc.wdata;
        sync_slave_pkg::OFS_PERIPH_IF:
          st_nxt.pir = acc.wdata & sync_slave_pkg::FLAG_WR_MASK;
        sync_slave_pkg::OFS_RX_STATUS:
          st_nxt.receive_status_control = acc.wdata & sync_slave_pkg::RX_CTRL_MASK;
        sync_slave_pkg::OFS_PORT_C_DIR: st_nxt.port_c_direction = acc.wdata;
        sync_slave_pkg::OFS_TX_STATUS:
          st_nxt.transmit_status_control = acc.wdata & sync_slave_pkg::TX_CTRL_MASK;
        sync_slave_pkg::OFS_TX_DATA: begin
          // Buffer full clears the empty flag
          st_nxt.txbuf = {st_r.transmit_status_control[sync_slave_pkg::TX_NINTH_BIT],
                          acc.wdata}; // R13 R19 R9
          st_nxt.txbuf_full = 1'b1; // R13
        end
        default: st_nxt.apf = st_r.apf;
      endcase
    end

    // Receive: no sleep gating, the master's clock does the work
    if (rx_mode && !st_r.overrun_error && sample_edge) begin // R1 R6
      st_nxt.rx_shift_reg = {din, st_r.rx_shift_reg[8:1]}; // R20
      if (rx_done) begin
        st_nxt.rcnt = 4'h0;
        if (st_nxt.rx_complete_flag) begin
          st_nxt.overrun_error = 1'b1;
        end else begin
          st_nxt.rx_complete_flag = 1'b1; // R7
          st_nxt.receive_data =
            st_r.receive_status_control[sync_slave_pkg::RX_NINE_BIT_SELECT] ?
            st_nxt.rx_shift_reg[7:0] : st_nxt.rx_shift_reg[8:1]; // R19
          st_nxt.rx_ninth_bit = st_nxt.rx_shift_reg[8] &
            st_r.receive_status_control[sync_slave_pkg::RX_NINE_BIT_SELECT];
        end
      end else begin
        st_nxt.rcnt = st_r.rcnt + 4'h1;
      end
    end

    // Transmit: shift on the drive edge after each sampled bit but the last
    if (tx_mode && st_r.tsr_full) begin // R1 R11
      if (drive_edge && st_r.tpend) begin
        st_nxt.tx_shift_reg   = {1'b0, st_r.tx_shift_reg[8:1]}; // R20
        st_nxt.tpend = 1'b0;
      end else if (tx_done) begin
        st_nxt.tsr_full = 1'b0;
        st_nxt.tcnt     = 4'h0;
      end else if (sample_edge) begin
        st_nxt.tcnt  = st_r.tcnt + 4'h1;
        st_nxt.tpend = 1'b1;
      end
    end
    if (tx_mode && !st_nxt.tsr_full && st_nxt.txbuf_full) begin
      st_nxt.tx_shift_reg        = st_nxt.txbuf; // R12
      st_nxt.tsr_full   = 1'b1;
      st_nxt.txbuf_full = 1'b0; // R12
      st_nxt.tcnt       = 4'h0;
      st_nxt.tpend      = 1'b0;
    end

    // Overrun clears only through the enables
    if (!st_nxt.receive_status_control[sync_slave_pkg::CONTINUOUS_RX_ENABLE]) begin
      st_nxt.overrun_error = 1'b0; // R18
      st_nxt.rcnt = 4'h0;
    end
    // Port disable clears flags, bit counters and receive shifter; data registers keep their values
    if (!st_nxt.receive_status_control[sync_slave_pkg::SERIAL_PORT_ENABLE]) begin // R18
      st_nxt.overrun_error       = 1'b0;
      st_nxt.rx_complete_flag       = 1'b0;
      st_nxt.rcnt       = 4'h0;
      st_nxt.rx_shift_reg        = 9'h000;
      st_nxt.tsr_full   = 1'b0;
      st_nxt.txbuf_full = 1'b0;
      st_nxt.tcnt       = 4'h0;
      st_nxt.tpend      = 1'b0;
    end

    st_nxt.dout = 2'h0;
    st_nxt.doe  = 2'h0;
    st_nxt.dout[st_nxt.apf[sync_slave_pkg::DATA_PIN_ALT]] =
      st_nxt.tx_shift_reg[0]; // R11 R15
    st_nxt.doe[st_nxt.apf[sync_slave_pkg::DATA_PIN_ALT]] = tx_mode;

    // Wake needs the system clock only on this side of the flags
    st_nxt.wake = sleep_in & (
      (st_nxt.rx_complete_flag & st_nxt.pie[sync_slave_pkg::RX_IRQ_BIT]) |
      (~st_nxt.txbuf_full & st_nxt.pie[sync_slave_pkg::TX_IRQ_BIT] &
       st_nxt.intc[sync_slave_pkg::PERIPHERAL_IRQ_ENABLE])); // R7 R12
    st_nxt.irq = st_nxt.intc[sync_slave_pkg::GLOBAL_IRQ_ENABLE] &
      st_nxt.intc[sync_slave_pkg::PERIPHERAL_IRQ_ENABLE] & (
      (st_nxt.rx_complete_flag & st_nxt.pie[sync_slave_pkg::RX_IRQ_BIT]) |
      (~st_nxt.txbuf_full &
       st_nxt.pie[sync_slave_pkg::TX_IRQ_BIT])); // R8
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign readdata_out    = st_r.rdata;
  assign data_pin_out    = st_r.dout;
  assign data_pin_oe_out = st_r.doe;
  assign wake_out        = st_r.wake;
  assign irq_out         = st_r.irq;
  assign irq_vector_out  = sync_slave_pkg::IRQ_VECTOR;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rx_flag;
    @(posedge clk_in) disable iff (!rstn_in)
      rx_done && !st_r.rx_complete_flag |=> st_r.rx_complete_flag;
  endproperty
  a_rx_flag: assert property (p_rx_flag) // R7
    else $error("completed word did not set receive flag");

  property p_rx_wake;
    @(posedge clk_in) disable iff (!rstn_in)
      rx_done && !st_r.rx_complete_flag && sleep_in &&
      st_r.pie[sync_slave_pkg::RX_IRQ_BIT] ##1 sleep_in |=> wake_out;
  endproperty
  a_rx_wake: assert property (p_rx_wake) // R7
    else $error("received word did not wake");

  property p_tx_move;
    @(posedge clk_in) disable iff (!rstn_in)
      tx_done && st_r.txbuf_full && !acc.wr_go
      |=> st_r.tsr_full && !st_r.txbuf_full;
  endproperty
  a_tx_move: assert property (p_tx_move) // R12
    else $error("buffered byte did not move into shifter");

  property p_tx_write;
    @(posedge clk_in) disable iff (!rstn_in)
      acc.wr_go && acc.lane0 && acc.addr == sync_slave_pkg::OFS_TX_DATA &&
      st_r.receive_status_control[sync_slave_pkg::SERIAL_PORT_ENABLE] &&
      !(tx_mode && (!st_r.tsr_full || tx_done))
      |=> st_r.txbuf_full;
  endproperty
  a_tx_write: assert property (p_tx_write) // R13
    else $error("data write did not clear transmit-empty flag");

  property p_unimpl_zero;
    @(posedge clk_in) disable iff (!rstn_in)
      acc.rd_prep && acc.addr == sync_slave_pkg::OFS_BAUD
      |=> readdata_out[5] == 1'b0 && readdata_out[2] == 1'b0 &&
          readdata_out[31:8] == 24'h00_0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // R14
    else $error("unimplemented bits read non-zero");

  property p_master_still;
    @(posedge clk_in) disable iff (!rstn_in)
      st_r.transmit_status_control[sync_slave_pkg::CLOCK_SOURCE_SELECT] &&
      st_r.receive_status_control[sync_slave_pkg::CONTINUOUS_RX_ENABLE] && !acc.wr_go
      |=> $stable(st_r.rx_shift_reg) && $stable(st_r.rcnt);
  endproperty
  a_master_still: assert property (p_master_still) // R2
    else $error("shifter moved outside slave mode");

  property p_overrun_clear;
    @(posedge clk_in) disable iff (!rstn_in)
      !st_r.receive_status_control[sync_slave_pkg::CONTINUOUS_RX_ENABLE] |-> !st_r.overrun_error;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) // R18
    else $error("overrun held with continuous receive disabled");

  property p_tx_drive;
    @(posedge clk_in) disable iff (!rstn_in)
      tx_mode && !acc.wr_go |=> data_pin_oe_out != 2'h0;
  endproperty
  a_tx_drive: assert property (p_tx_drive) // R11
    else $error("data pin not driven in slave transmit");

endmodule : sync_slave_serial

// *** hw/sync_slave_pkg.sv ***
package sync_slave_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_ALT_PIN    = 6'h00;
  localparam logic [5:0] OFS_BAUD       = 6'h04;
  localparam logic [5:0] OFS_GLOBAL_IRQ = 6'h08;
  localparam logic [5:0] OFS_PERIPH_IE  = 6'h0c;
  localparam logic [5:0] OFS_PERIPH_IF  = 6'h10;
  localparam logic [5:0] OFS_RX_DATA    = 6'h14;
  localparam logic [5:0] OFS_RX_STATUS  = 6'h18;
  localparam logic [5:0] OFS_PORT_C_DIR = 6'h1c;
  localparam logic [5:0] OFS_TX_STATUS  = 6'h20;
  localparam logic [5:0] OFS_TX_DATA    = 6'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SERIAL_PORT_ENABLE   = 7;
  localparam int RX_NINE_BIT_SELECT   = 6;
  localparam int SINGLE_RX_ENABLE     = 5;
  localparam int CONTINUOUS_RX_ENABLE = 4;
  localparam int FRAMING_ERROR        = 2;
  localparam int OVERRUN_ERROR        = 1;
  localparam int RX_NINTH_BIT         = 0;
  localparam int CLOCK_SOURCE_SELECT  = 7;
  localparam int TX_NINE_BIT_SELECT   = 6;
  localparam int TX_ENABLE            = 5;
  localparam int SYNC_MODE            = 4;
  localparam int TX_SHIFT_EMPTY       = 1;
  localparam int TX_NINTH_BIT         = 0;
  localparam int RX_IDLE              = 6;
  localparam int CLOCK_POLARITY       = 4;
  localparam int GLOBAL_IRQ_ENABLE    = 7;
  localparam int PERIPHERAL_IRQ_ENABLE = 6;
  localparam int RX_IRQ_BIT           = 5;
  localparam int TX_IRQ_BIT           = 4;
  localparam int CLOCK_PIN_ALT        = 2;
  localparam int DATA_PIN_ALT         = 1;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BAUD_WR_MASK  = 8'h1b;
  localparam logic [7:0] RX_CTRL_MASK  = 8'hf8;
  localparam logic [7:0] TX_CTRL_MASK  = 8'hf9;
  localparam logic [7:0] FLAG_WR_MASK  = 8'hcf;
  localparam logic [7:0] RESET_ZERO    = 8'h00;
  localparam logic [3:0] LAST_BIT_8    = 4'h7;
  localparam logic [3:0] LAST_BIT_9    = 4'h8;
  localparam logic [11:0] IRQ_VECTOR   = 12'h004;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rd_prep;
    logic       rd_go;
    logic       wr_go;
    logic       lane0;
    logic [5:0] addr;
    logic [7:0] wdata;
  } bus_acc_t;

  typedef struct packed {
    logic [1:0] data_lvl;
    logic [1:0] clk_lvl;
  } link_pins_t;

  function automatic logic slave_mode(input logic [7:0] rx_ctl,
                                      input logic [7:0] tx_ctl);
    slave_mode = rx_ctl[SERIAL_PORT_ENABLE] & tx_ctl[SYNC_MODE] &
                 ~tx_ctl[CLOCK_SOURCE_SELECT];
  endfunction : slave_mode

endpackage : sync_slave_pkg

// *** hw/pin_sync.sv ***
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] pin_in,
  output logic [W-1:0]      level_out
);

  // ----------------------------------------------------------------
  // Three stages; level moves only when stages two and three agree
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;

  sync_st_t st_r;
  sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.q;

  property p_level_follows;
    @(posedge clk_in) disable iff (!rstn_in)
      (st_r.s2 != st_r.q) && (st_r.s2 == st_r.s3) |=> level_out != $past(level_out);
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("synchronised level did not follow agreed stages");

endmodule : pin_sync

// *** hw/bus_front.sv ***
`timescale 1ns/10ps
module bus_front (
  input  wire logic                      clk_in,
  input  wire logic                      rstn_in,
  input  wire logic [5:0]                address_in,
  input  wire logic                      read_in,
  input  wire logic                      write_in,
  input  wire logic [31:0]               writedata_in,
  input  wire logic [3:0]                byteenable_in,
  output logic                           waitrequest_out,
  output sync_slave_pkg::bus_acc_t       acc_out
);

  // ----------------------------------------------------------------
  // One wait cycle per access, so read data can come from a flop
  // ----------------------------------------------------------------
  typedef struct packed {
    logic waitreq;
  } front_st_t;

  front_st_t st_r;
  front_st_t st_nxt;
  logic      req;

  assign req = read_in | write_in;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.waitreq = ~(req & st_r.waitreq);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // Idle slave holds waitrequest high
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign waitrequest_out = st_r.waitreq;
  assign acc_out.rd_prep = read_in & st_r.waitreq;
  assign acc_out.rd_go   = read_in & ~st_r.waitreq;
  assign acc_out.wr_go   = write_in & ~st_r.waitreq;
  assign acc_out.lane0   = byteenable_in[0];
  assign acc_out.addr    = address_in;
  assign acc_out.wdata   = writedata_in[7:0];

  property p_one_wait;
    @(posedge clk_in) disable iff (!rstn_in)
      req && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("access not answered after exactly one wait cycle");

endmodule : bus_front

// *** tb/ext_master.sv ***
`timescale 1ns/10ps
module ext_master (
  input  wire logic       clk_in,
  input  wire logic       loc_in,
  input  wire logic [1:0] line_in,
  output logic      [1:0] ck_out,
  output logic      [1:0] dt_out
);
  // ----
  // Word transfer
  // ----
  logic ninth = 1'b0;  // Set for a frame with a ninth bit of one
  initial begin
    ck_out = 2'h3;
    dt_out = 2'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt
  // Clock idles high and stands still between words
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    for (int i = 0; i < (ninth ? 9 : 8); i++) begin
      dt_out[loc_in] <= (i < 8) ? d[i[2:0]] : 1'b1;
      wt(2);
      ck_out[loc_in] <= 1'b0;
      wt(4);
      if (i < 8) q[i] = line_in[loc_in];
      ck_out[loc_in] <= 1'b1;
      wt(2);
    end
    dt_out <= ~dt_out;  // Inverted lines show no stale bit
    wt(1);
  endtask : xfer
endmodule : ext_master

// *** tb/test_sync_slave_serial.sv ***
`timescale 1ns/10ps
module test_sync_slave_serial;
  logic        clk_in, rstn_in, read_r, write_r, sleep_r, loc_r;
  logic [5:0]  addr_r;
  logic [31:0] wdata_r, readdata_out, seed;
  logic [1:0]  ck, dt_m, dout, doe, line;
  logic        waitrequest_out, wake_out, irq_out;
  logic [11:0] irq_vector_out;
  logic [7:0]  q, b0, b1, got;
  int          n_mismatch, num_checks, cyc;
  assign line = (doe & dout) | (~doe & dt_m);
  sync_slave_serial dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .address_in(addr_r), .read_in(read_r), .write_in(write_r),
    .writedata_in(wdata_r), .byteenable_in(4'h1),
    .waitrequest_out(waitrequest_out), .readdata_out(readdata_out),
    .sleep_in(sleep_r), .clock_pin_in(ck), .data_pin_in(line),
    .data_pin_out(dout), .data_pin_oe_out(doe), .wake_out(wake_out),
    .irq_out(irq_out), .irq_vector_out(irq_vector_out));
  ext_master m (.clk_in(clk_in), .loc_in(loc_r), .line_in(line),
    .ck_out(ck), .dt_out(dt_m));
  // ----
  // Helpers
  // ----
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic close_out;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string s, input logic [11:0] e,
                     input logic [11:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One wait state is normal; the loop copes with more
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    @(posedge clk_in);
    read_r  <= ~w;
    write_r <= w;
    addr_r  <= a;
    wdata_r <= {24'h00_0000, d};
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0) @(posedge clk_in);
    q = readdata_out[7:0];
    read_r  <= 1'b0;
    write_r <= 1'b0;
  endtask : bus
  task automatic rchk(input string s, input logic [5:0] a,
                      input logic [7:0] mk, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(s, {4'h0, e}, {4'h0, q & mk});
  endtask : rchk
  task automatic wait_wake;
    for (int i = 0; i < 200 && wake_out !== 1'b1; i++) @(posedge clk_in);
  endtask : wait_wake
  // ----
  // Scenarios
  // ----
  initial begin
    {rstn_in, read_r, write_r, sleep_r, loc_r} = 5'h00;
    addr_r = 6'h00;
    wdata_r = 32'h0000_0000;
    seed = 32'h304a_5797;
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    rchk("tx_status", sync_slave_pkg::OFS_TX_STATUS, 8'hff, 8'h02);
    rchk("rx_flag", sync_slave_pkg::OFS_PERIPH_IF, 8'h20, 8'h00);
    rchk("unmapped", 6'h3c, 8'hff, 8'h00);
    bus(1'b1, sync_slave_pkg::OFS_BAUD, 8'h24);
    rchk("baud_unimpl", sync_slave_pkg::OFS_BAUD, 8'h24, 8'h00);
    // Master mode must not shift while asleep
    bus(1'b1, sync_slave_pkg::OFS_RX_STATUS, 8'hb0);
    bus(1'b1, sync_slave_pkg::OFS_TX_STATUS, 8'h90);
    sleep_r <= 1'b1;
    m.xfer(8'h5a, got);
    rchk("master_flag", sync_slave_pkg::OFS_PERIPH_IF, 8'h20, 8'h00);
    sleep_r <= 1'b0;
    bus(1'b1, sync_slave_pkg::OFS_ALT_PIN, 8'h06);
    loc_r <= 1'b1;
    bus(1'b1, sync_slave_pkg::OFS_TX_STATUS, 8'h10);
    bus(1'b1, sync_slave_pkg::OFS_PERIPH_IE, 8'h20);
    bus(1'b1, sync_slave_pkg::OFS_GLOBAL_IRQ, 8'hc0);
    sleep_r <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      b0 = (k == 0) ? 8'hff : seed[7:0];
      m.xfer(b0, got);
      wait_wake;
      chk("wake", 12'h001, {11'h000, wake_out});
      chk("irq", 12'h001, {11'h000, irq_out});
      chk("vector", 12'h004, irq_vector_out);
      rchk("rx_data", sync_slave_pkg::OFS_RX_DATA, 8'hff, b0);
      rchk("rx_flag_clr", sync_slave_pkg::OFS_PERIPH_IF, 8'h20, 8'h00);
    end
    m.xfer(8'h11, got);
    m.xfer(8'h22, got);
    rchk("overrun", sync_slave_pkg::OFS_RX_STATUS, 8'h02, 8'h02);
    rchk("rx_kept", sync_slave_pkg::OFS_RX_DATA, 8'hff, 8'h11);
    bus(1'b1, sync_slave_pkg::OFS_RX_STATUS, 8'h80);
    rchk("ovr_clr", sync_slave_pkg::OFS_RX_STATUS, 8'h02, 8'h00);
    bus(1'b1, sync_slave_pkg::OFS_RX_STATUS, 8'hd0);
    m.ninth = 1'b1;
    m.xfer(8'ha5, got);
    wait_wake;
    rchk("rx_ninth", sync_slave_pkg::OFS_RX_STATUS, 8'h01, 8'h01);
    rchk("rx9_data", sync_slave_pkg::OFS_RX_DATA, 8'hff, 8'ha5);
    m.ninth = 1'b0;
    bus(1'b1, sync_slave_pkg::OFS_RX_STATUS, 8'h80);
    // Slave transmit, two words queued before sleep
    sleep_r <= 1'b0;
    bus(1'b1, sync_slave_pkg::OFS_PERIPH_IE, 8'h10);
    bus(1'b1, sync_slave_pkg::OFS_TX_STATUS, 8'h30);
    seed = xs(seed);
    b0 = seed[7:0];
    b1 = seed[15:8];
    bus(1'b1, sync_slave_pkg::OFS_TX_DATA, b0);
    bus(1'b1, sync_slave_pkg::OFS_TX_DATA, b1);
    rchk("tx_full", sync_slave_pkg::OFS_PERIPH_IF, 8'h10, 8'h00);
    sleep_r <= 1'b1;
    m.xfer(8'h00, got);
    chk("tx_word0", {4'h0, b0}, {4'h0, got});
    wait_wake;
    chk("tx_wake", 12'h001, {11'h000, wake_out});
    bus(1'b1, sync_slave_pkg::OFS_TX_DATA, 8'h3c);
    rchk("tx_refill", sync_slave_pkg::OFS_PERIPH_IF, 8'h10, 8'h00);
    m.xfer(8'h00, got);
    chk("tx_word1", {4'h0, b1}, {4'h0, got});
    close_out;
  end
endmodule : test_sync_slave_serial
